// ===== verilog/mf_pin_pkg.sv
// Purpose: shared constants for the multi-function pin control block
// Assumes: 10 MHz system clock, 8-bit register port with 7-bit register numbers
// Notes:   pulse length derived from its time and the clock rate
package mf_pin_pkg;
    // register numbers
    localparam logic [6:0] REG_STICKY_FLAGS   = 7'h60;
    localparam logic [6:0] REG_PIN_FUNC_CTRL  = 7'h62;
    localparam logic [6:0] REG_RESERVED_A     = 7'h63;
    localparam logic [6:0] REG_RESERVED_B     = 7'h64;
    // pin_function_control fields
    localparam int FLD_FUNC_LSB    = 4;
    localparam int FLD_CLK_SEL     = 3;
    localparam int FLD_DURATION    = 2;
    localparam int FLD_INPUT_VAL   = 1;
    localparam int FLD_OUTPUT_VAL  = 0;
    localparam logic [3:0] RST_FUNC    = 4'h0;
    localparam logic       RST_BIT     = 1'b0;
    localparam logic [7:0] RST_STICKY  = 8'h00;
    localparam logic [7:0] READ_ZERO   = 8'h00;
    // sticky flag bit positions
    localparam int STK_SHORT_LSB   = 5;
    localparam int STK_BUTTON      = 3;
    localparam int STK_HEADSET     = 2;
    localparam int STK_NG_LEFT     = 1;
    localparam int STK_NG_RIGHT    = 0;
    // pin function codes
    localparam logic [3:0] FN_DISABLED   = 4'h0;
    localparam logic [3:0] FN_ADC_WCLK   = 4'h1;
    localparam logic [3:0] FN_CLK_DIV1   = 4'h2;
    localparam logic [3:0] FN_CLK_DIV2   = 4'h3;
    localparam logic [3:0] FN_CLK_DIV4   = 4'h4;
    localparam logic [3:0] FN_CLK_DIV8   = 4'h5;
    localparam logic [3:0] FN_INT_SHORT  = 4'h6;
    localparam logic [3:0] FN_INT_NGATE  = 4'h7;
    localparam logic [3:0] FN_GP_INPUT   = 4'h8;
    localparam logic [3:0] FN_GP_OUTPUT  = 4'h9;
    localparam logic [3:0] FN_RESERVED   = 4'hA;
    localparam logic [3:0] FN_WORD_CLK   = 4'hB;
    localparam logic [3:0] FN_INT_BUTTON = 4'hC;
    localparam logic [3:0] FN_INT_JACK   = 4'hD;
    localparam logic [3:0] FN_INT_JK_BTN = 4'hE;
    localparam logic [3:0] FN_INT_ALL    = 4'hF;
    // timing
    localparam int CLK_FREQ_KHZ     = 10000;
    localparam int PULSE_TIME_MS    = 2;
    localparam int PULSE_CYCLES_DEF = PULSE_TIME_MS * CLK_FREQ_KHZ;
    localparam int PULSE_CNT_W      = 16;
    localparam int DIV_CNT_W        = 3;
    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_HIGH = 3'b010,
        PS_LOW  = 3'b100
    } pulse_state_t;
endpackage

// ===== verilog/multi_function_pin_control.sv
// Purpose: control logic of one multi-function pin: role select, clock out, interrupt out, plain in/out
// Assumes: all inputs synchronous to i_clk_sys; clock sources far slower than i_clk_sys
// Notes:   register reads answer one cycle after i_reg_rd
// Behaviour
// RULE_01 - code 0000 disabled, 0001 converter-input word clock
// RULE_02 - codes 0010..0101 drive clock divided 1,2,4,8
// RULE_03 - 0110 short interrupt, 0111 noise-gate interrupt
// RULE_04 - 1000 general input, 1001 general output
// RULE_05 - host never writes reserved code 1010
// RULE_06 - 1011 word clock, input or output
// RULE_07 - 1100 active-high button interrupt
// RULE_08 - 1101 jack interrupt, 1110 jack or button
// RULE_09 - 1111 ORs all four interrupt sources
// RULE_10 - clock select: 0 PLL, 1 divider mux
// RULE_11 - duration bit 0: single 2ms pulse
// RULE_12 - duration bit 1: repeat until flags read
// RULE_13 - input-value bit reflects external pin level
// RULE_14 - output mode drives output-value bit
// RULE_15 - reset clears selector and all control bits
// RULE_16 - reserved registers read zero, never written
// RULE_17 - sticky flags latch events, cleared on read
// RULE_18 - release driver when not driving out
`timescale 1ns/1ns
module multi_function_pin_control
    import mf_pin_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYCLES_DEF
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic [6:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_adc_wclk,
    input  wire logic       i_wclk_out,
    input  wire logic       i_wclk_is_output,
    input  wire logic       i_pll_clk,
    input  wire logic       i_clkdiv_clk,
    input  wire logic [2:0] i_evt_short,
    input  wire logic       i_evt_button,
    input  wire logic       i_evt_headset,
    input  wire logic       i_evt_ng_left,
    input  wire logic       i_evt_ng_right,
    input  wire logic       i_pin,
    output logic            o_pin,
    output logic            o_pin_oe,
    output logic            o_wclk_in
);
    localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(PULSE_CYCLES - 1);

    logic [3:0]             func;
    logic                   clk_sel;
    logic                   duration;
    logic                   out_val;
    logic                   in_val;
    logic [7:0]             sticky;
    logic [7:0]             evt_vec;
    logic                   sticky_rd;
    logic                   src_clk;
    logic                   src_prev;
    logic [DIV_CNT_W-1:0]   div_cnt;
    logic                   int_src;
    logic                   int_prev;
    logic                   int_trig;
    logic                   int_mode;
    logic                   pending;
    pulse_state_t           pstate;
    logic [PULSE_CNT_W-1:0] pcnt;
    logic                   pulse_out;
    logic                   next_pin;
    logic                   next_oe;
    logic [7:0]             next_rdata;

    assign sticky_rd = i_reg_rd && (i_reg_addr == REG_STICKY_FLAGS);
    assign evt_vec   = {i_evt_short, 1'b0, i_evt_button, i_evt_headset, i_evt_ng_left, i_evt_ng_right};

    // control register; writes to reserved registers are dropped
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            func     <= RST_FUNC; // RULE_15
            clk_sel  <= RST_BIT; // RULE_15
            duration <= RST_BIT; // RULE_15
            out_val  <= RST_BIT; // RULE_15
        end else if (i_reg_wr && i_reg_addr == REG_PIN_FUNC_CTRL) begin
            func     <= i_reg_wdata[FLD_FUNC_LSB +: 4];
            clk_sel  <= i_reg_wdata[FLD_CLK_SEL];
            duration <= i_reg_wdata[FLD_DURATION];
            out_val  <= i_reg_wdata[FLD_OUTPUT_VAL];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_val <= RST_BIT;
        end else begin
            in_val <= i_pin; // RULE_13
        end
    end

    // sticky flags: an event in the clearing read's cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sticky
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sticky[gi] <= RST_STICKY[gi];
                end else if (evt_vec[gi]) begin
                    sticky[gi] <= 1'b1; // RULE_17
                end else if (sticky_rd) begin
                    sticky[gi] <= 1'b0; // RULE_17
                end
            end
        end
    endgenerate

    always_comb begin
        next_rdata = READ_ZERO; // RULE_16
        unique case (i_reg_addr)
            REG_STICKY_FLAGS:  next_rdata = sticky;
            REG_PIN_FUNC_CTRL: next_rdata = {func, clk_sel, duration, in_val, out_val}; // RULE_13
            default:           next_rdata = READ_ZERO; // RULE_16
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= READ_ZERO;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end
    end

    // clock source and power-of-two divider, counted on source rising edges
    assign src_clk = clk_sel ? i_clkdiv_clk : i_pll_clk; // RULE_10

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_prev <= 1'b0;
            div_cnt  <= '0;
        end else begin
            src_prev <= src_clk;
            if (src_clk && !src_prev) begin
                div_cnt <= div_cnt + 1'b1; // RULE_02
            end
        end
    end

    // interrupt source selection
    always_comb begin
        int_src  = 1'b0;
        int_mode = 1'b1;
        unique case (func)
            FN_INT_SHORT:  int_src = |i_evt_short; // RULE_03
            FN_INT_NGATE:  int_src = i_evt_ng_left | i_evt_ng_right; // RULE_03
            FN_INT_BUTTON: int_src = i_evt_button; // RULE_07
            FN_INT_JACK:   int_src = i_evt_headset; // RULE_08
            FN_INT_JK_BTN: int_src = i_evt_headset | i_evt_button; // RULE_08
            FN_INT_ALL:    int_src = i_evt_headset | i_evt_button | (|i_evt_short)
                                     | i_evt_ng_left | i_evt_ng_right; // RULE_09
            default:       int_mode = 1'b0;
        endcase
    end

    assign int_trig = int_src && !int_prev;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_prev <= 1'b0;
            pending  <= 1'b0;
        end else begin
            int_prev <= int_src;
            if (int_trig) begin
                pending <= 1'b1; // RULE_12
            end else if (sticky_rd || !int_mode) begin
                pending <= 1'b0; // RULE_12
            end
        end
    end

    // pulse generator: one pulse per event, or a train while pending
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pstate <= PS_IDLE;
            pcnt   <= '0;
        end else begin
            unique case (pstate)
                PS_IDLE: begin
                    pcnt <= '0;
                    if (int_mode && (int_trig || (duration && pending))) begin
                        pstate <= PS_HIGH; // RULE_11
                    end
                end
                PS_HIGH: begin
                    if (pcnt == PULSE_LAST) begin
                        pcnt   <= '0;
                        pstate <= (duration && pending) ? PS_LOW : PS_IDLE; // RULE_11 RULE_12
                    end else begin
                        pcnt <= pcnt + 1'b1;
                    end
                end
                PS_LOW: begin
                    if (pcnt == PULSE_LAST) begin
                        pcnt   <= '0;
                        pstate <= (duration && pending) ? PS_HIGH : PS_IDLE; // RULE_12
                    end else begin
                        pcnt <= pcnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // a single-pulse button interrupt also covers the whole press
    assign pulse_out = (pstate == PS_HIGH)
                       || (func == FN_INT_BUTTON && !duration && i_evt_button); // RULE_07

    always_comb begin
        next_pin = 1'b0;
        next_oe  = 1'b1;
        unique case (func)
            FN_DISABLED:  next_oe  = 1'b0; // RULE_01 RULE_18
            FN_ADC_WCLK:  next_pin = i_adc_wclk; // RULE_01
            FN_CLK_DIV1:  next_pin = src_prev; // RULE_02
            FN_CLK_DIV2:  next_pin = div_cnt[0]; // RULE_02
            FN_CLK_DIV4:  next_pin = div_cnt[1]; // RULE_02
            FN_CLK_DIV8:  next_pin = div_cnt[2]; // RULE_02
            FN_GP_INPUT:  next_oe  = 1'b0; // RULE_04 RULE_18
            FN_GP_OUTPUT: next_pin = out_val; // RULE_04 RULE_14
            FN_RESERVED:  next_oe  = 1'b0;
            FN_WORD_CLK: begin
                next_pin = i_wclk_is_output & i_wclk_out; // RULE_06
                next_oe  = i_wclk_is_output; // RULE_06 RULE_18
            end
            default:      next_pin = pulse_out; // RULE_03 RULE_07 RULE_08 RULE_09
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin     <= 1'b0;
            o_pin_oe  <= 1'b0;
            o_wclk_in <= 1'b0;
        end else begin
            o_pin     <= next_pin;
            o_pin_oe  <= next_oe;
            o_wclk_in <= (func == FN_WORD_CLK && !i_wclk_is_output) ? i_pin : 1'b0; // RULE_06
        end
    end

    a_disabled_released: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_18
        (func == FN_DISABLED || func == FN_GP_INPUT) |=> !o_pin_oe)
        else $error("pin driven while released mode");
    a_gpo_drives_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_14
        (func == FN_GP_OUTPUT) |=> (o_pin_oe && o_pin == $past(out_val)))
        else $error("general output not following value bit");
    a_reserved_reads_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_16
        (i_reg_rd && (i_reg_addr == REG_RESERVED_A || i_reg_addr == REG_RESERVED_B))
        |=> o_reg_rdata == READ_ZERO)
        else $error("reserved register read nonzero");
    a_input_value_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_13
        (i_reg_rd && i_reg_addr == REG_PIN_FUNC_CTRL) |=> o_reg_rdata[FLD_INPUT_VAL] == $past(i_pin, 2))
        else $error("input value bit wrong");
    a_sticky_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_17
        (i_evt_button && sticky_rd) |=> sticky[STK_BUTTON])
        else $error("event lost on clearing read");
    a_sticky_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_17
        (sticky_rd && evt_vec == 8'h00) |=> sticky == 8'h00)
        else $error("sticky flags not cleared by read");
    a_single_pulse_ends: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_11
        (pstate == PS_HIGH && pcnt == PULSE_LAST && !duration) |=> pstate == PS_IDLE)
        else $error("single pulse did not end");
    a_train_continues: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_12
        (pstate == PS_HIGH && pcnt == PULSE_LAST && duration && pending) |=> pstate == PS_LOW)
        else $error("pulse train stopped while pending");
    a_trigger_starts: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_03 RULE_09
        (pstate == PS_IDLE && int_mode && int_trig) |=> ##1 o_pin && o_pin_oe)
        else $error("interrupt event did not drive pin");
    a_adc_wclk_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_01
        (func == FN_ADC_WCLK) |=> o_pin == $past(i_adc_wclk))
        else $error("word clock not routed");
    a_clk_source_pick: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_10 RULE_02
        (func == FN_CLK_DIV1 && $stable(func))
        |-> o_pin == ($past(clk_sel, 2) ? $past(i_clkdiv_clk, 2) : $past(i_pll_clk, 2)))
        else $error("divide-by-one clock wrong");
    a_wclk_in_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_06
        (func == FN_WORD_CLK && !i_wclk_is_output) |=> (!o_pin_oe && o_wclk_in == $past(i_pin)))
        else $error("word clock input not released or forwarded");
    a_reset_state: assert property (@(posedge i_clk_sys) $rose(i_rst_n) // RULE_15
        |-> func == FN_DISABLED && !clk_sel && !duration && !out_val)
        else $error("control not cleared by reset");

    c_single_pulse: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pstate == PS_HIGH && !duration ##1 pstate == PS_IDLE);
    c_pulse_train: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pstate == PS_LOW ##1 pstate == PS_HIGH);
    c_gp_output: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        func == FN_GP_OUTPUT && o_pin);
    c_sticky_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        sticky_rd && sticky != 8'h00);
    c_word_clk_in: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        func == FN_WORD_CLK && !o_pin_oe);
endmodule // multi_function_pin_control

// ===== tb/mf_pin_far_side.sv
// Purpose: external logic on the multi-function pin, resolves the wire level
// Assumes: weak pull-up on the pin when nobody drives it
// Notes:   the external driver is enabled by the bench only while the device releases the pin
`timescale 1ns/1ns
module mf_pin_far_side (
    input  wire logic i_dev_level,
    input  wire logic i_dev_oe,
    input  wire logic i_ext_en,
    input  wire logic i_ext_level,
    output logic      o_wire_level
);
    // device driver wins, then external source, then the pull-up
    assign o_wire_level = i_dev_oe ? i_dev_level : (i_ext_en ? i_ext_level : 1'b1);
endmodule // mf_pin_far_side

// ===== tb/multi_function_pin_control_tb_top.sv
// Purpose: self-checking bench for the multi-function pin control block
// Assumes: PULSE_CYCLES shortened to 8, clock sources made from a free counter
// Notes:   random register traffic from a fixed seed plus hand-written interrupt cases
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module multi_function_pin_control_tb_top;
    import mf_pin_pkg::*;
    localparam int PC = 8;
    logic       clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, adc_wclk = 1'b0, wclk_out = 1'b0;
    logic       wclk_is_out = 1'b0, pll = 1'b0, cdiv = 1'b0, btn = 1'b0, hs = 1'b0, ngl = 1'b0, ngr = 1'b0;
    logic       ext_lvl = 1'b0, pin_in, pin_out, pin_oe, wclk_in;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00, rdata, d, rb, cnt = 8'h00;
    logic [2:0] short = 3'h0, s;
    logic [3:0] fns [6] = '{FN_INT_SHORT, FN_INT_NGATE, FN_INT_BUTTON, FN_INT_JACK, FN_INT_JK_BTN, FN_INT_ALL};
    int         errors = 0, checks_done = 0, hi, rs, ex;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cnt  <= cnt + 8'h01;
        pll  <= cnt[2];
        cdiv <= cnt[3];
    end
    multi_function_pin_control #(.PULSE_CYCLES(PC)) dut (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .i_adc_wclk(adc_wclk), .i_wclk_out(wclk_out),
        .i_wclk_is_output(wclk_is_out), .i_pll_clk(pll), .i_clkdiv_clk(cdiv), .i_evt_short(short),
        .i_evt_button(btn), .i_evt_headset(hs), .i_evt_ng_left(ngl), .i_evt_ng_right(ngr),
        .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe), .o_wclk_in(wclk_in));
    mf_pin_far_side far (.i_dev_level(pin_out), .i_dev_oe(pin_oe), .i_ext_en(~pin_oe),
        .i_ext_level(ext_lvl), .o_wire_level(pin_in));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        tick(1);
        v = rdata;
    endtask
    task automatic count_hi(input int n, output int h, output int r);
        logic pv;
        h = 0;
        r = 0;
        pv = pin_out;
        repeat (n) begin
            tick(1);
            h += int'(pin_out);
            r += int'(pin_out & ~pv);
            pv = pin_out;
        end
    endtask
    task automatic evt(input int src, input logic [2:0] sv);
        @(posedge clk_sys);
        case (src)
            0: short <= sv;
            1: begin ngl <= sv[0]; ngr <= ~sv[0]; end
            2: btn <= 1'b1;
            default: hs <= 1'b1;
        endcase
        @(posedge clk_sys);
        {short, ngl, ngr, btn, hs} <= 7'h00;
    endtask
    function automatic logic fires(input logic [3:0] fn, input int src);
        case (fn)
            FN_INT_SHORT:  return src == 0;
            FN_INT_NGATE:  return src == 1;
            FN_INT_BUTTON: return src == 2;
            FN_INT_JACK:   return src == 3;
            FN_INT_JK_BTN: return src >= 2;
            default:       return 1'b1;
        endcase
    endfunction
    function automatic logic [7:0] sticky_exp(input int src, input logic [2:0] sv);
        case (src)
            0: return {sv, 5'h00};
            1: return {6'h00, sv[0], ~sv[0]};
            2: return 8'h08;
            default: return 8'h04;
        endcase
    endfunction
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(82));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (fns[i]) begin
            if (i < 4) begin
                reg_rd(i == 0 ? REG_PIN_FUNC_CTRL : i == 1 ? REG_RESERVED_A : i == 2 ? REG_RESERVED_B
                       : REG_STICKY_FLAGS, d);
                `CHK("reset_read", 8'h00, d)
            end
        end
        $display("test reset values finished");
        repeat (24) begin
            d = 8'($urandom);
            if (d[7:4] == FN_RESERVED) d[7:4] = FN_GP_INPUT;
            @(posedge clk_sys);
            ext_lvl <= 1'($urandom);
            reg_wr(REG_PIN_FUNC_CTRL, d);
            tick(2);
            if (d[7:4] == FN_GP_OUTPUT) begin
                `CHK("gp_out_level", {1'b1, d[0]}, {pin_oe, pin_out})
            end
            if (d[7:4] == FN_DISABLED || d[7:4] == FN_GP_INPUT || d[7:4] == FN_WORD_CLK) begin
                `CHK("released_oe", 1'b0, pin_oe)
                if (d[7:4] == FN_WORD_CLK) `CHK("wclk_in", ext_lvl, wclk_in)
                reg_rd(REG_PIN_FUNC_CTRL, rb);
                `CHK("in_value", ext_lvl, rb[FLD_INPUT_VAL])
            end else reg_rd(REG_PIN_FUNC_CTRL, rb);
            `CHK("readback", d & 8'hFD, rb & 8'hFD)
        end
        $display("test register traffic finished");
        for (int v = 0; v < 2; v++) begin
            reg_wr(REG_PIN_FUNC_CTRL, {FN_ADC_WCLK, 4'h0});
            adc_wclk <= 1'(v);
            tick(3);
            `CHK("adc_wclk_pin", {1'b1, 1'(v)}, {pin_oe, pin_out})
            reg_wr(REG_PIN_FUNC_CTRL, {FN_WORD_CLK, 4'h0});
            wclk_is_out <= 1'b1;
            wclk_out <= 1'(v);
            tick(3);
            `CHK("wclk_out_pin", {1'b1, 1'(v)}, {pin_oe, pin_out})
            @(posedge clk_sys);
            wclk_is_out <= 1'b0;
            ext_lvl     <= 1'(v);
            tick(3);
            `CHK("wclk_in_pin", {1'b0, 1'(v)}, {pin_oe, wclk_in})
        end
        $display("test word clocks finished");
        for (int sel = 0; sel < 2; sel++) begin
            for (int k = 0; k < 4; k++) begin
                reg_wr(REG_PIN_FUNC_CTRL, {FN_CLK_DIV1 + 4'(k), 1'(sel), 3'h0});
                tick(20);
                count_hi(512, hi, rs);
                ex = (sel == 1 ? 32 : 64) >> k;
                `CHK("clk_rises", 1'b1, (rs >= ex - 1 && rs <= ex + 1))
            end
        end
        $display("test clock outputs finished");
        foreach (fns[i]) begin
            for (int src = 0; src < 4; src++) begin
                reg_wr(REG_PIN_FUNC_CTRL, {fns[i], 4'h0});
                tick(4);
                reg_rd(REG_STICKY_FLAGS, d);
                s = 3'($urandom_range(7, 1));
                evt(src, s);
                count_hi(PC * 3, hi, rs);
                if (fires(fns[i], src)) `CHK("pulse_len", 1'b1, (hi >= PC && hi <= PC + 1))
                else `CHK("no_pulse", 0, hi)
                reg_rd(REG_STICKY_FLAGS, d);
                `CHK("sticky_set", sticky_exp(src, s), d)
                reg_rd(REG_STICKY_FLAGS, d);
                `CHK("sticky_clear", 8'h00, d)
            end
        end
        $display("test interrupt pulses finished");
        reg_wr(REG_PIN_FUNC_CTRL, {FN_INT_JACK, 4'h4});
        tick(4);
        reg_rd(REG_STICKY_FLAGS, d);
        evt(3, 3'h0);
        count_hi(PC * 8, hi, rs);
        `CHK("repeat_pulses", 1'b1, rs >= 3)
        reg_rd(REG_STICKY_FLAGS, d);
        tick(PC * 2 + 4);
        count_hi(PC * 4, hi, rs);
        `CHK("train_stopped", 0, hi)
        $display("test repeating interrupt finished");
        // button event in the very cycle of the clearing read must survive
        @(posedge clk_sys);
        addr <= REG_STICKY_FLAGS;
        rd   <= 1'b1;
        btn  <= 1'b1;
        @(posedge clk_sys);
        {rd, btn} <= 2'b00;
        reg_rd(REG_STICKY_FLAGS, d);
        `CHK("sticky_set_wins", 8'h08, d)
        $display("test set over clear finished");
        reg_wr(REG_PIN_FUNC_CTRL, {FN_GP_OUTPUT, 4'hD});
        ext_lvl <= 1'b0;
        tick(2);
        `CHK("gp_out_before_reset", 2'b11, {pin_oe, pin_out})
        @(posedge clk_sys);
        rst_n <= 1'b0;
        tick(1);
        `CHK("pins_in_reset", 2'b00, {pin_oe, pin_out})
        @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_rd(REG_PIN_FUNC_CTRL, d);
        `CHK("reset_clears", 8'h00, d)
        $display("test mid-run reset finished");
        tally_and_finish;
    end
endmodule // multi_function_pin_control_tb_top
